// ---- shared/power_stage_pkg.sv ----
package power_stage_pkg;
   // Bus and compare widths
   localparam int DATA_W = 16;
   localparam int CMP_W = 12;
   localparam int ADDR_W = 4;
   localparam int FRAC_W = 4;
   localparam int FRAC_LSB = 12;
   // Register addresses
   localparam logic [3:0] ADDR_SET_A = 4'h0;
   localparam logic [3:0] ADDR_RESET_A = 4'h1;
   localparam logic [3:0] ADDR_SET_B = 4'h2;
   localparam logic [3:0] ADDR_RESET_B = 4'h3;
   localparam logic [3:0] ADDR_WAVE_CONFIG = 4'h4;
   localparam logic [3:0] ADDR_WAVE_CONTROL = 4'h5;
   localparam logic [3:0] ADDR_SYNC_OUT = 4'h6;
   localparam logic [3:0] ADDR_OUT_MATRIX = 4'h7;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_COUNT = 4'h9;
   // wave_config fields
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_FIFTY_BIT = 2;
   localparam int CFG_HOLD_BIT = 3;
   localparam int CFG_UOW_BIT = 4;
   localparam int CFG_FWM_LSB = 5;
   localparam int CFG_ENH_BIT = 7;
   // wave_control fields
   localparam int CTL_RUN_BIT = 0;
   localparam int CTL_FRAME_IRQ_EN_BIT = 1;
   // sync_out_config field: output polarity (1 = active low)
   localparam int SOC_POL_BIT = 0;
   // Reset values
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [CMP_W-1:0] CMP_RESET = 12'h000;
   // Ramp offsets
   localparam logic [CMP_W-1:0] ONE_PERIOD = 12'h001;
   // Frame of sixteen cycles, interrupt after cycle fourteen
   localparam logic [FRAC_W-1:0] FRAME_IRQ_CYCLE = 4'hE;
   // Active set layout
   localparam int ACT_SA_LSB = 0;
   localparam int ACT_RA_LSB = 12;
   localparam int ACT_SB_LSB = 24;
   localparam int ACT_RB_LSB = 36;
   localparam int ACT_SOC_LSB = 52;
   localparam int ACT_OM_LSB = 60;
   localparam int ACT_W = 64;
   // Running modes
   typedef enum logic [1:0] {
      MODE_FOUR_RAMP,
      MODE_TWO_RAMP,
      MODE_ONE_RAMP,
      MODE_CENTER
   } run_mode_type;
endpackage

// ---- src/active_set_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
// Active copy of the whole compare and output set
module active_set_reg (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic load_in,
   input wire logic [power_stage_pkg::ACT_W-1:0] set_in,
   output logic [power_stage_pkg::ACT_W-1:0] set_out
);
   logic [power_stage_pkg::ACT_W-1:0] set_q; // Working values

   // Whole set moves in one edge so no cycle sees a mix
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         set_q <= '0;
      end else if (load_in) begin
         set_q <= set_in;
      end
   end

   assign set_out = set_q;
endmodule // active_set_reg
`default_nettype wire

// ---- src/fwm_frame.sv ----
`timescale 1ns/1ps
`default_nettype none
// Sixteen cycle frame counter and stretch pattern
module fwm_frame (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic restart_in,
   input wire logic cycle_end_in,
   input wire logic [power_stage_pkg::FRAC_W-1:0] frac_in,
   output logic stretch_out,
   output logic frame_end_out,
   output logic [power_stage_pkg::FRAC_W-1:0] index_out
);
   logic [power_stage_pkg::FRAC_W-1:0] index_q; // Cycle number in frame

   // Bit reversal spreads stretched cycles evenly
   function automatic logic [power_stage_pkg::FRAC_W-1:0] bit_rev(
      input logic [power_stage_pkg::FRAC_W-1:0] v);
      bit_rev = {v[0], v[1], v[2], v[3]};
   endfunction

   // Frame position, wraps after sixteen cycles
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         index_q <= '0;
      end else if (restart_in) begin
         index_q <= '0;
      end else if (cycle_end_in) begin
         index_q <= index_q + 4'h1;
      end
   end

   assign stretch_out = (bit_rev(index_q) < frac_in);
   assign frame_end_out = cycle_end_in && (index_q == power_stage_pkg::FRAME_IRQ_CYCLE);
   assign index_out = index_q;
endmodule // fwm_frame
`default_nettype wire

// ---- src/power_stage_waveform_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two output waveform core with coherent compare update
module power_stage_waveform_core (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic [power_stage_pkg::ADDR_W-1:0] addr_in,
   input wire logic [power_stage_pkg::DATA_W-1:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [power_stage_pkg::DATA_W-1:0] rd_data_out,
   output logic out_a_out,
   output logic out_b_out,
   output logic frame_end_irq_out
);
   // Ramp states of one cycle
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RAMP0,
      ST_RAMP1,
      ST_RAMP2,
      ST_RAMP3
   } wave_state_type;

   localparam int CW = power_stage_pkg::CMP_W;

   // Software side values
   logic [CW-1:0] set_a_q; // Buffered set_a_compare
   logic [CW-1:0] reset_a_q; // Buffered reset_a_compare
   logic [CW-1:0] set_b_q; // Buffered set_b_compare
   logic [power_stage_pkg::DATA_W-1:0] reset_b_q; // Buffered reset_b_compare and divider
   logic [7:0] sync_out_config_q; // Buffered sync_out_config
   logic [3:0] output_matrix_q; // Buffered output_matrix_reg
   logic [7:0] wave_config_q; // Mode and update options
   logic [7:0] wave_control_q; // Run and interrupt enable
   // Update control
   logic rb_pending_q; // reset_b written since last cycle end load
   logic uow_active_q; // update_on_write as sampled at cycle end
   // Waveform state
   wave_state_type st_q; // Current ramp
   logic [CW-1:0] cnt_q; // Ramp counter
   logic out_a_q; // Registered out_a
   logic out_b_q; // Registered out_b
   logic irq_q; // Frame end interrupt pulse
   logic [power_stage_pkg::DATA_W-1:0] rd_data_q; // Read answer

   // Decoded controls
   logic run;
   logic hold;
   logic fifty;
   logic enh;
   logic [1:0] fwm_select;
   power_stage_pkg::run_mode_type mode;
   // Active set and derived values
   logic [power_stage_pkg::ACT_W-1:0] load_vec;
   logic [power_stage_pkg::ACT_W-1:0] act_vec;
   logic [CW-1:0] act_sa;
   logic [CW-1:0] act_ra;
   logic [CW-1:0] act_sb;
   logic [power_stage_pkg::DATA_W-1:0] act_rb;
   logic [7:0] act_soc;
   logic [3:0] act_om;
   logic [CW-1:0] eff_sa;
   logic [CW-1:0] eff_ra;
   logic [CW-1:0] eff_sb;
   logic [CW-1:0] eff_rb;
   logic stretch;
   logic frame_end;
   logic [power_stage_pkg::FRAC_W-1:0] frame_index;
   logic [CW-1:0] top;
   logic [CW-1:0] val;
   logic at_top;
   logic last_ramp;
   logic cycle_end;
   logic load_en;
   logic wave_a;
   logic wave_b;

   // Write decode shared by all register processes
   function automatic logic wr_hit(input logic [power_stage_pkg::ADDR_W-1:0] a);
      wr_hit = wr_en_in && (addr_in == a);
   endfunction

   // Add one period when the stretch applies
   function automatic logic [CW-1:0] add_ext(input logic [CW-1:0] v, input logic e);
      add_ext = v + {{(CW-1){1'b0}}, e};
   endfunction

   assign run = wave_control_q[power_stage_pkg::CTL_RUN_BIT];
   assign hold = wave_config_q[power_stage_pkg::CFG_HOLD_BIT];
   assign fifty = wave_config_q[power_stage_pkg::CFG_FIFTY_BIT];
   assign enh = wave_config_q[power_stage_pkg::CFG_ENH_BIT];
   assign fwm_select = wave_config_q[power_stage_pkg::CFG_FWM_LSB +: 2];
   assign mode = power_stage_pkg::run_mode_type'(wave_config_q[power_stage_pkg::CFG_MODE_LSB +: 2]);

   // Compare registers written by software
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         set_a_q <= power_stage_pkg::CMP_RESET;
         reset_a_q <= power_stage_pkg::CMP_RESET;
         set_b_q <= power_stage_pkg::CMP_RESET;
         reset_b_q <= '0;
      end else begin
         if (wr_hit(power_stage_pkg::ADDR_SET_A)) begin
            set_a_q <= wr_data_in[CW-1:0];
         end
         if (wr_hit(power_stage_pkg::ADDR_RESET_A)) begin
            reset_a_q <= wr_data_in[CW-1:0];
         end
         if (wr_hit(power_stage_pkg::ADDR_SET_B)) begin
            set_b_q <= wr_data_in[CW-1:0];
         end
         if (wr_hit(power_stage_pkg::ADDR_RESET_B)) begin
            reset_b_q <= wr_data_in;
         end
      end
   end

   // Configuration and control registers
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wave_config_q <= power_stage_pkg::CFG_RESET;
         wave_control_q <= power_stage_pkg::CTL_RESET;
         sync_out_config_q <= '0;
         output_matrix_q <= '0;
      end else begin
         if (wr_hit(power_stage_pkg::ADDR_WAVE_CONFIG)) begin
            wave_config_q <= wr_data_in[7:0];
         end
         if (wr_hit(power_stage_pkg::ADDR_WAVE_CONTROL)) begin
            wave_control_q <= wr_data_in[7:0];
         end
         if (wr_hit(power_stage_pkg::ADDR_SYNC_OUT)) begin
            sync_out_config_q <= wr_data_in[7:0];
         end
         if (wr_hit(power_stage_pkg::ADDR_OUT_MATRIX)) begin
            output_matrix_q <= wr_data_in[3:0];
         end
      end
   end

   // Set offered to the active copy, part B mirrored into A in fifty mode
   assign load_vec = {output_matrix_q, sync_out_config_q, reset_b_q, set_b_q,
                      fifty ? reset_b_q[CW-1:0] : reset_a_q,
                      fifty ? set_b_q : set_a_q};

   // Transfer gate: at once when stopped, else at cycle end
   always_comb begin
      if (!run) begin
         load_en = 1'b1;
      end else if (!cycle_end) begin
         load_en = 1'b0;
      end else if (uow_active_q) begin
         load_en = rb_pending_q;
      end else begin
         load_en = !hold;
      end
   end

   // Pending reset_b write, a new write beats the clear
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rb_pending_q <= 1'b0;
      end else if (wr_hit(power_stage_pkg::ADDR_RESET_B)) begin
         rb_pending_q <= 1'b1;
      end else if (load_en && cycle_end) begin
         rb_pending_q <= 1'b0;
      end
   end

   // update_on_write takes effect only from a cycle end on
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         uow_active_q <= 1'b0;
      end else if (cycle_end) begin
         uow_active_q <= wave_config_q[power_stage_pkg::CFG_UOW_BIT];
      end
   end

   // Active copy loaded as one unit
   active_set_reg u_active (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(load_en),
      .set_in(load_vec),
      .set_out(act_vec)
   );

   assign act_sa = act_vec[power_stage_pkg::ACT_SA_LSB +: CW];
   assign act_ra = act_vec[power_stage_pkg::ACT_RA_LSB +: CW];
   assign act_sb = act_vec[power_stage_pkg::ACT_SB_LSB +: CW];
   assign act_rb = act_vec[power_stage_pkg::ACT_RB_LSB +: power_stage_pkg::DATA_W];
   assign act_soc = act_vec[power_stage_pkg::ACT_SOC_LSB +: 8];
   assign act_om = act_vec[power_stage_pkg::ACT_OM_LSB +: 4];

   // Frame counter and stretch pattern
   fwm_frame u_frame (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .restart_in(!run),
      .cycle_end_in(cycle_end),
      .frac_in(act_rb[power_stage_pkg::FRAC_LSB +: power_stage_pkg::FRAC_W]),
      .stretch_out(stretch),
      .frame_end_out(frame_end),
      .index_out(frame_index)
   );

   // Stretched compares; center always stretches its ramp top
   assign eff_rb = add_ext(act_rb[CW-1:0], enh && stretch &&
                          (!fwm_select[1] || mode == power_stage_pkg::MODE_CENTER));
   assign eff_ra = add_ext(act_ra, enh && stretch && fwm_select == 2'b01);
   assign eff_sb = add_ext(act_sb, enh && stretch && fwm_select[1]);
   assign eff_sa = add_ext(act_sa, enh && stretch && fwm_select == 2'b11);

   // Ramp top and last ramp for each mode
   always_comb begin
      top = eff_rb;
      last_ramp = 1'b0;
      case (mode)
         power_stage_pkg::MODE_FOUR_RAMP: begin
            // Dead ramps run set+2, on ramps run reset periods
            case (st_q)
               ST_RAMP0: top = eff_sa + power_stage_pkg::ONE_PERIOD;
               ST_RAMP1: top = (eff_ra == '0) ? '0 : eff_ra - power_stage_pkg::ONE_PERIOD;
               ST_RAMP2: top = eff_sb + power_stage_pkg::ONE_PERIOD;
               default: top = (eff_rb == '0) ? '0 : eff_rb - power_stage_pkg::ONE_PERIOD;
            endcase
            last_ramp = (st_q == ST_RAMP3);
         end
         power_stage_pkg::MODE_TWO_RAMP: begin
            // One ramp per output
            top = (st_q == ST_RAMP0) ? eff_ra : eff_rb;
            last_ramp = (st_q == ST_RAMP1);
         end
         power_stage_pkg::MODE_ONE_RAMP: begin
            // Single ramp up to reset_b
            top = eff_rb;
            last_ramp = (st_q == ST_RAMP0);
         end
         default: begin
            // Down ramp then up ramp, both to reset_b
            top = eff_rb;
            last_ramp = (st_q == ST_RAMP1);
         end
      endcase
   end

   // Center down ramp seen as reset_b minus the up count
   assign val = (mode == power_stage_pkg::MODE_CENTER && st_q == ST_RAMP0) ?
                (eff_rb - cnt_q) : cnt_q;
   assign at_top = (cnt_q == top);
   assign cycle_end = (st_q != ST_IDLE) && at_top && last_ramp;

   // Ramp sequencing; stop always returns to a fresh cycle start
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
      end else if (!run) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               st_q <= ST_RAMP0;
               cnt_q <= '0;
            end
            ST_RAMP0, ST_RAMP1, ST_RAMP2, ST_RAMP3: begin
               if (!at_top) begin
                  cnt_q <= cnt_q + power_stage_pkg::ONE_PERIOD;
               end else if (last_ramp) begin
                  st_q <= ST_RAMP0;
                  cnt_q <= '0;
               end else begin
                  st_q <= wave_state_type'(st_q + 3'h1);
                  cnt_q <= '0;
               end
            end
            default: begin
               st_q <= ST_IDLE;
               cnt_q <= '0;
            end
         endcase
      end
   end

   // Raw output levels from ramp and compares
   always_comb begin
      wave_a = 1'b0;
      wave_b = 1'b0;
      case (mode)
         power_stage_pkg::MODE_FOUR_RAMP: begin
            wave_a = (st_q == ST_RAMP1);
            wave_b = (st_q == ST_RAMP3);
         end
         power_stage_pkg::MODE_TWO_RAMP: begin
            wave_a = (st_q == ST_RAMP0) && (val > eff_sa);
            wave_b = (st_q == ST_RAMP1) && (val > eff_sb);
         end
         power_stage_pkg::MODE_ONE_RAMP: begin
            // Windows are independent so they may overlap
            wave_a = (st_q == ST_RAMP0) && (val > eff_sa) && (val <= eff_ra);
            wave_b = (st_q == ST_RAMP0) && (val > eff_sb) && (val <= eff_rb);
         end
         default: begin
            // reset_a plays no part here
            wave_a = (st_q != ST_IDLE) && (val < eff_sa);
            wave_b = (st_q != ST_IDLE) && (val >= eff_sb);
         end
      endcase
   end

   // Output flops with polarity; inactive level while stopped
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
      end else begin
         out_a_q <= (run && wave_a) ^ act_soc[power_stage_pkg::SOC_POL_BIT];
         out_b_q <= (run && wave_b) ^ act_soc[power_stage_pkg::SOC_POL_BIT];
      end
   end

   // Frame end interrupt pulse
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= frame_end && wave_control_q[power_stage_pkg::CTL_FRAME_IRQ_EN_BIT];
      end
   end

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_q <= '0;
      end else if (!rd_en_in) begin
         rd_data_q <= '0;
      end else begin
         case (addr_in)
            power_stage_pkg::ADDR_SET_A: rd_data_q <= {4'h0, set_a_q};
            power_stage_pkg::ADDR_RESET_A: rd_data_q <= {4'h0, reset_a_q};
            power_stage_pkg::ADDR_SET_B: rd_data_q <= {4'h0, set_b_q};
            power_stage_pkg::ADDR_RESET_B: rd_data_q <= reset_b_q;
            power_stage_pkg::ADDR_WAVE_CONFIG: rd_data_q <= {8'h00, wave_config_q};
            power_stage_pkg::ADDR_WAVE_CONTROL: rd_data_q <= {8'h00, wave_control_q};
            power_stage_pkg::ADDR_SYNC_OUT: rd_data_q <= {8'h00, sync_out_config_q};
            power_stage_pkg::ADDR_OUT_MATRIX: rd_data_q <= {12'h000, output_matrix_q};
            power_stage_pkg::ADDR_STATUS: begin
               // Live state of the generator
               rd_data_q <= {act_om, 2'b00, rb_pending_q, uow_active_q, frame_index,
                             1'b0, (st_q != ST_IDLE), out_b_q, out_a_q};
            end
            power_stage_pkg::ADDR_COUNT: rd_data_q <= {4'h0, val};
            default: rd_data_q <= '0; // Unmapped reads as zero
         endcase
      end
   end

   assign rd_data_out = rd_data_q;
   assign out_a_out = out_a_q;
   assign out_b_out = out_b_q;
   assign frame_end_irq_out = irq_q;
endmodule // power_stage_waveform_core
`default_nettype wire

// ---- verif/bridge_driver_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Gate driver stand-in: measures pulse widths and the cycle length
module bridge_driver_model (
   input wire logic sys_clk_in,
   input wire logic gate_a_in,
   input wire logic gate_b_in,
   output logic [15:0] on_a_out,
   output logic [15:0] on_b_out,
   output logic [15:0] period_out
);
   logic [15:0] run_a, run_b, run_p; // Running counts
   logic prev_a, prev_b; // Last sampled gate levels
   // Width of each high pulse, spacing of gate A rising edges
   always_ff @(posedge sys_clk_in) begin
      prev_a <= gate_a_in;
      prev_b <= gate_b_in;
      run_a <= gate_a_in ? run_a + 16'h0001 : 16'h0000;
      run_b <= gate_b_in ? run_b + 16'h0001 : 16'h0000;
      if (prev_a && !gate_a_in) on_a_out <= run_a;
      if (prev_b && !gate_b_in) on_b_out <= run_b;
      if (gate_a_in && !prev_a) begin
         period_out <= run_p;
         run_p <= 16'h0001;
      end else begin
         run_p <= run_p + 16'h0001;
      end
   end
endmodule // bridge_driver_model
`default_nettype wire

// ---- verif/power_stage_waveform_core_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port level checks of the waveform core
module power_stage_waveform_core_asserts (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic [power_stage_pkg::ADDR_W-1:0] addr_in,
   input wire logic [power_stage_pkg::DATA_W-1:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [power_stage_pkg::DATA_W-1:0] rd_data_out,
   input wire logic out_a_out,
   input wire logic out_b_out,
   input wire logic frame_end_irq_out
);
   logic run_q, irq_en_q; // Last written control bits
   logic [1:0] mode_q; // Last written running mode
   logic [2:0] stop_cnt_q; // Cycles spent stopped, saturating
   logic pol_q; // Last written output polarity
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   // Shadow of control and mode writes
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         run_q <= 1'b0;
         irq_en_q <= 1'b0;
         mode_q <= 2'h0;
         stop_cnt_q <= 3'h0;
         pol_q <= 1'b0;
      end else begin
         if (wr_en_in && addr_in == power_stage_pkg::ADDR_WAVE_CONTROL) begin
            run_q <= wr_data_in[power_stage_pkg::CTL_RUN_BIT];
            irq_en_q <= wr_data_in[power_stage_pkg::CTL_FRAME_IRQ_EN_BIT];
         end
         if (wr_en_in && addr_in == power_stage_pkg::ADDR_WAVE_CONFIG) mode_q <= wr_data_in[1:0];
         if (wr_en_in && addr_in == power_stage_pkg::ADDR_SYNC_OUT) begin
            pol_q <= wr_data_in[power_stage_pkg::SOC_POL_BIT];
         end
         // A polarity write restarts the settling count
         if (run_q || (wr_en_in && addr_in == power_stage_pkg::ADDR_SYNC_OUT)) begin
            stop_cnt_q <= 3'h0;
         end else if (stop_cnt_q != 3'h7) begin
            stop_cnt_q <= stop_cnt_q + 3'h1;
         end
      end
   end
   a_reset_outs_low: assert property ($rose(reset_n_in) |-> !out_a_out && !out_b_out)
      else $error("outputs active right after reset");
   a_stopped_outs_idle: assert property (stop_cnt_q >= 3'h3 |->
      out_a_out == pol_q && out_b_out == pol_q)
      else $error("outputs not at idle level while stopped");
   a_ramp_no_overlap: assert property (run_q && !mode_q[1] |-> !(out_a_out && out_b_out))
      else $error("outputs overlap in four or two ramp mode");
   a_four_dead_b: assert property (run_q && mode_q == 2'h0 && $fell(out_a_out) |-> !out_b_out [*2])
      else $error("dead time before part B under two periods");
   a_four_dead_a: assert property (run_q && mode_q == 2'h0 && $fell(out_b_out) |-> !out_a_out [*2])
      else $error("dead time before part A under two periods");
   a_irq_one_cycle: assert property (frame_end_irq_out |=> !frame_end_irq_out)
      else $error("frame end pulse longer than one cycle");
   a_irq_enabled: assert property (frame_end_irq_out |-> $past(irq_en_q))
      else $error("frame end pulse while disabled");
   a_status_running: assert property (rd_en_in && addr_in == power_stage_pkg::ADDR_STATUS
      && $stable(run_q) |=> rd_data_out[2] == $past(run_q))
      else $error("status running bit wrong");
endmodule // power_stage_waveform_core_asserts
bind power_stage_waveform_core power_stage_waveform_core_asserts chk_i (.sys_clk_in(sys_clk_in),
   .reset_n_in(reset_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
   .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .out_a_out(out_a_out),
   .out_b_out(out_b_out), .frame_end_irq_out(frame_end_irq_out));
`default_nettype wire

// ---- verif/power_stage_waveform_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench of the waveform core
module power_stage_waveform_core_tb;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [power_stage_pkg::ADDR_W-1:0] addr_in = 4'h0;
   logic [power_stage_pkg::DATA_W-1:0] wr_data_in = 16'h0000;
   logic wr_en_in = 1'b0;
   logic rd_en_in = 1'b0;
   logic [power_stage_pkg::DATA_W-1:0] rd_data_out;
   logic out_a_out, out_b_out, frame_end_irq_out;
   logic [15:0] on_a, on_b, per; // Measured by the driver model
   logic [15:0] v; // Read result
   int error_cnt = 0;
   int n_compared = 0;
   int n; // Frame length
   power_stage_waveform_core uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .out_a_out(out_a_out), .out_b_out(out_b_out),
      .frame_end_irq_out(frame_end_irq_out));
   bridge_driver_model drv (.sys_clk_in(sys_clk_in), .gate_a_in(out_a_out),
      .gate_b_in(out_b_out), .on_a_out(on_a), .on_b_out(on_b), .period_out(per));
   // 200 MHz clock
   initial begin
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   // Compare and count
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One write, one idle cycle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr_in <= a;
      wr_data_in <= d;
      wr_en_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_en_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   // One read, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      addr_in <= a;
      rd_en_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_en_in <= 1'b0;
      #1 d = rd_data_out;
      @(posedge sys_clk_in);
   endtask
   // Stop, program a full set, then start again
   task automatic start(input logic [15:0] cfg, sa, ra, sb, rb, ctl);
      @(posedge sys_clk_in);
      wr(power_stage_pkg::ADDR_WAVE_CONTROL, 16'h0000);
      wr(power_stage_pkg::ADDR_WAVE_CONFIG, cfg);
      wr(power_stage_pkg::ADDR_SET_A, sa);
      wr(power_stage_pkg::ADDR_RESET_A, ra);
      wr(power_stage_pkg::ADDR_SET_B, sb);
      wr(power_stage_pkg::ADDR_RESET_B, rb);
      wr(power_stage_pkg::ADDR_WAVE_CONTROL, ctl);
      repeat (80) @(posedge sys_clk_in);
   endtask
   // Shapes of the four running modes
   task automatic t_modes();
      start(16'h0000, 16'h1, 16'h3, 16'h2, 16'h4, 16'h1);
      chk("four on_a", 16'd3, on_a);
      chk("four on_b", 16'd4, on_b);
      chk("four period", 16'd14, per);
      rd(power_stage_pkg::ADDR_STATUS, v);
      chk("running", 16'h0004, v & 16'h0004);
      start(16'h0001, 16'h1, 16'h5, 16'h2, 16'h6, 16'h1);
      chk("two on_a", 16'd4, on_a);
      chk("two on_b", 16'd4, on_b);
      chk("two period", 16'd13, per);
      start(16'h0002, 16'h1, 16'h4, 16'h3, 16'h7, 16'h1);
      chk("one on_a", 16'd3, on_a);
      chk("one on_b", 16'd4, on_b);
      start(16'h0003, 16'h2, 16'h9, 16'h3, 16'h5, 16'h1);
      chk("center on_a", 16'd4, on_a);
      chk("center on_b", 16'd6, on_b);
      chk("center period", 16'd12, per);
      start(16'h0004, 16'h9, 16'h9, 16'h1, 16'h3, 16'h1);
      chk("fifty on_a", 16'd3, on_a);
      chk("fifty period", 16'd12, per);
      // Stopped with inverted polarity: idle level is high on both outputs
      wr(power_stage_pkg::ADDR_WAVE_CONTROL, 16'h0000);
      wr(power_stage_pkg::ADDR_SYNC_OUT, 16'h0001);
      wr(power_stage_pkg::ADDR_OUT_MATRIX, 16'h000A);
      repeat (4) @(posedge sys_clk_in);
      chk("inverted idle", 16'h0003, {14'h0, out_b_out, out_a_out});
      rd(power_stage_pkg::ADDR_STATUS, v);
      chk("matrix", 16'hA000, v & 16'hF000);
      rd(power_stage_pkg::ADDR_COUNT, v);
      chk("count stopped", 16'h0000, v);
      wr(power_stage_pkg::ADDR_SYNC_OUT, 16'h0000);
   endtask
   // Hold, release, then update on write over hold
   task automatic t_update();
      start(16'h0000, 16'h1, 16'h3, 16'h2, 16'h4, 16'h1);
      wr(power_stage_pkg::ADDR_WAVE_CONFIG, 16'h0008);
      wr(power_stage_pkg::ADDR_RESET_B, 16'h0006);
      wr(power_stage_pkg::ADDR_SET_A, 16'h0004);
      repeat (60) @(posedge sys_clk_in);
      chk("held on_b", 16'd4, on_b);
      wr(power_stage_pkg::ADDR_WAVE_CONFIG, 16'h0000);
      repeat (60) @(posedge sys_clk_in);
      chk("released on_b", 16'd6, on_b);
      chk("released period", 16'd19, per);
      wr(power_stage_pkg::ADDR_WAVE_CONFIG, 16'h0018);
      repeat (40) @(posedge sys_clk_in);
      wr(power_stage_pkg::ADDR_RESET_B, 16'h0005);
      repeat (60) @(posedge sys_clk_in);
      chk("autoload on_b", 16'd5, on_b);
   endtask
   // Frame length for each stretch selection, divider 3
   task automatic t_enh();
      for (int s = 0; s < 4; s++) begin
         start(16'(16'h0080 | (s << 5)), 16'h1, 16'h3, 16'h2, 16'h3004, 16'h3);
         for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
               @(posedge sys_clk_in);
               #1 n++;
            end while (frame_end_irq_out !== 1'b1 && n < 2000);
         end
         chk("frame length", 16'(224 + 3 * (s[0] ? 2 : 1)), 16'(n));
      end
   endtask
   // Verdict and end of run
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #200000;
      error_cnt++;
      give_verdict();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      @(posedge sys_clk_in);
      #1 chk("out_a idle", 16'h0000, {15'h0, out_a_out});
      @(posedge sys_clk_in);
      rd(power_stage_pkg::ADDR_WAVE_CONFIG, v);
      chk("config reset", {8'h00, power_stage_pkg::CFG_RESET}, v);
      rd(4'hF, v);
      chk("unmapped", 16'h0000, v);
      t_modes();
      t_update();
      t_enh();
      give_verdict();
   end
endmodule // power_stage_waveform_core_tb
`default_nettype wire
